// [design/psc_power_state_ctrl.sv]
// Power-state sequencer with AXI4-Lite control and status registers.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Three states, stepping only through the middle.
// - Normal enable transitions reverse immediately.
// - Fault, supply or reset transitions always complete.
// - Start in hardware shutdown after any reset.
// - Hardware shutdown resets registers, blocks bus.
// - Leaving hardware shutdown loads trim, then software shutdown.
// - Trim failure flagged on reaching software shutdown.
// - Reset pin low forces hardware shutdown.
// - Core supply loss forces hardware shutdown.
// - Exit hardware shutdown needs core and speaker supplies and reset high.
// - Low-rail indicator asserted while active on battery.
// - Interrupt pin polarity and drive are configurable.
// - Enable bit drives power-up/down with completion interrupts.
// - Software shutdown keeps registers and allows writes.
// - Supply faults while active force software shutdown.
module psc_power_state_ctrl #(
  parameter int TRIM_LIMIT = psc_pkg::TRIM_LIMIT_CYCLES
) (
  // Clock and reset.
  input  wire logic               clk_sys_i,
  input  wire logic               sys_rst_i,
  // Pins and supply indications.
  input  wire logic               hw_reset_n_i,
  input  wire psc_pkg::psc_supply_t supplies_i,
  // Output stage and trim loader.
  input  wire logic               amp_on_battery_i,
  output logic                    blocks_enable_o,
  output logic                    trim_load_start_o,
  input  wire logic               trim_load_done_i,
  input  wire logic               trim_load_ok_i,
  // Open-drain low-rail indicator.
  output logic                    low_rail_indicator_o,
  output logic                    low_rail_indicator_oe_o,
  // Interrupt pin.
  output logic                    irq_o,
  output logic                    irq_oe_o,
  // AXI4-Lite write channels.
  input  wire logic [3:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [3:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  typedef enum logic [2:0] {
    ST_HW_SHDN,
    ST_INIT,
    ST_SW_SHDN,
    ST_POWER_UP,
    ST_ACTIVE,
    ST_POWER_DOWN,
    ST_FAULT_DOWN
  } psc_state_t;

  psc_state_t           state;
  psc_state_t           next_state;
  logic                 reset_pin_ok;
  psc_pkg::psc_supply_t sup;
  logic                 hw_cause;
  logic                 active_fault;
  logic                 can_activate;
  logic                 ramp_start;
  logic                 ramp_done;
  logic                 trim_start;
  logic                 trim_timeout;
  logic                 trim_failed;
  logic                 regs_clear;
  logic [2:0]           ctrl;
  logic [psc_pkg::FLAG_W-1:0] flags;
  logic [psc_pkg::FLAG_W-1:0] mask;
  logic [psc_pkg::FLAG_W-1:0] flag_set;
  logic [psc_pkg::FLAG_W-1:0] flag_clr;
  logic                 wr_fire;
  logic                 rd_fire;
  logic                 wr_ok;
  logic                 rd_ok;
  logic [31:0]          rd_value;
  logic                 irq_level;

  // Reset pin: release is seen only after the synchroniser.
  psc_sync #(.W(1), .RESET_VAL(1'b0)) u_reset_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (hw_reset_n_i),
    .sync_o    (reset_pin_ok)
  );

  psc_sync #(.W($bits(psc_pkg::psc_supply_t)), .RESET_VAL('0)) u_supply_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (supplies_i),
    .sync_o    (sup)
  );

  psc_timer #(.W(psc_pkg::TIMER_W)) u_ramp_timer (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (ramp_start),
    .len_i     (psc_pkg::TIMER_W'(psc_pkg::RAMP_CYCLES)),
    .done_o    (ramp_done)
  );

  psc_timer #(.W(psc_pkg::TIMER_W)) u_trim_timer (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (trim_start),
    .len_i     (psc_pkg::TIMER_W'(TRIM_LIMIT)),
    .done_o    (trim_timeout)
  );

  assign hw_cause     = !reset_pin_ok || !sup.core_good;
  assign active_fault = hw_cause || !sup.core_uv_ok || !sup.speaker_uv_ok ||
                        !sup.battery_uv_ok || !sup.analog_good;
  assign can_activate = ctrl[psc_pkg::CTRL_ENABLE_BIT] && !active_fault;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_HW_SHDN: begin
        if (!hw_cause && sup.core_uv_ok && sup.speaker_uv_ok) begin
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (hw_cause) begin
          next_state = ST_HW_SHDN;
        end else if (trim_load_done_i || trim_timeout) begin
          next_state = ST_SW_SHDN;
        end
      end
      ST_SW_SHDN: begin
        if (hw_cause) begin
          next_state = ST_HW_SHDN;
        end else if (can_activate) begin
          next_state = ST_POWER_UP;
        end
      end
      ST_POWER_UP: begin
        if (active_fault) begin
          next_state = ST_FAULT_DOWN;
        end else if (!ctrl[psc_pkg::CTRL_ENABLE_BIT]) begin
          next_state = ST_POWER_DOWN;
        end else if (ramp_done) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (active_fault) begin
          next_state = ST_FAULT_DOWN;
        end else if (!ctrl[psc_pkg::CTRL_ENABLE_BIT]) begin
          next_state = ST_POWER_DOWN;
        end
      end
      ST_POWER_DOWN: begin
        if (active_fault) begin
          next_state = ST_FAULT_DOWN;
        end else if (can_activate) begin
          next_state = ST_POWER_UP;
        end else if (ramp_done) begin
          next_state = ST_SW_SHDN;
        end
      end
      ST_FAULT_DOWN: begin
        if (ramp_done) begin
          next_state = ST_SW_SHDN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= ST_HW_SHDN;
    end else begin
      state <= next_state;
    end
  end

  // Ramp timer restarts on every entry to a transition state.
  assign ramp_start = (next_state != state) && ((next_state == ST_POWER_UP) ||
                      (next_state == ST_POWER_DOWN) || (next_state == ST_FAULT_DOWN));
  assign trim_start = (state == ST_HW_SHDN) && (next_state == ST_INIT);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      trim_load_start_o <= 1'b0;
    end else begin
      trim_load_start_o <= trim_start;
    end
  end

  // A timeout or an unsuccessful load both count as a failure.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || trim_start) begin
      trim_failed <= 1'b0;
    end else if (state == ST_INIT) begin
      if (trim_timeout || (trim_load_done_i && !trim_load_ok_i)) begin
        trim_failed <= 1'b1;
      end
    end
  end

  // Hardware shutdown holds every register at its default.
  assign regs_clear = sys_rst_i || (state == ST_HW_SHDN);

  always_comb begin
    flag_set = '0;
    flag_set[psc_pkg::FLAG_UP_BIT]    = (state == ST_POWER_UP) && (next_state == ST_ACTIVE);
    flag_set[psc_pkg::FLAG_DOWN_BIT]  = (state == ST_POWER_DOWN) && (next_state == ST_SW_SHDN);
    flag_set[psc_pkg::FLAG_TRIM_BIT]  = (state == ST_INIT) && (next_state == ST_SW_SHDN) &&
                                        (trim_failed || trim_timeout ||
                                         (trim_load_done_i && !trim_load_ok_i));
    flag_set[psc_pkg::FLAG_FAULT_BIT] = (state == ST_FAULT_DOWN) && (next_state == ST_SW_SHDN);
  end

  // Bus is refused while the device sits in hardware shutdown.
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_ok = (state != ST_HW_SHDN) && s_axi_wstrb[0] &&
                 (s_axi_awaddr == psc_pkg::CTRL_OFS || s_axi_awaddr == psc_pkg::FLAGS_OFS ||
                  s_axi_awaddr == psc_pkg::MASK_OFS);
  assign flag_clr = (wr_fire && wr_ok && s_axi_awaddr == psc_pkg::FLAGS_OFS) ?
                    s_axi_wdata[psc_pkg::FLAG_W-1:0] : '0;

  always_ff @(posedge clk_sys_i) begin
    if (regs_clear) begin
      ctrl <= psc_pkg::CTRL_RESET;
    end else if (wr_fire && wr_ok && s_axi_awaddr == psc_pkg::CTRL_OFS) begin
      ctrl <= s_axi_wdata[2:0];
    end else if (state == ST_ACTIVE && active_fault) begin
      ctrl[psc_pkg::CTRL_ENABLE_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (regs_clear) begin
      mask <= psc_pkg::MASK_RESET;
    end else if (wr_fire && wr_ok && s_axi_awaddr == psc_pkg::MASK_OFS) begin
      mask <= s_axi_wdata[psc_pkg::FLAG_W-1:0];
    end
  end

  // An event in the clearing cycle survives the clear.
  always_ff @(posedge clk_sys_i) begin
    if (regs_clear) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= psc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? psc_pkg::RESP_OKAY : psc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_value = '0;
    rd_ok    = state != ST_HW_SHDN;
    unique case (s_axi_araddr)
      psc_pkg::CTRL_OFS:   rd_value[2:0] = ctrl;
      psc_pkg::STATUS_OFS: begin
        if (state == ST_ACTIVE) begin
          rd_value[1:0] = psc_pkg::PWR_ACTIVE;
        end else if (state == ST_HW_SHDN) begin
          rd_value[1:0] = psc_pkg::PWR_HW;
        end else begin
          rd_value[1:0] = psc_pkg::PWR_SW;
        end
        rd_value[psc_pkg::STATUS_BUSY_BIT] = (state == ST_POWER_UP) || (state == ST_POWER_DOWN) ||
                                             (state == ST_FAULT_DOWN) || (state == ST_INIT);
        rd_value[psc_pkg::STATUS_BATT_BIT] = amp_on_battery_i;
      end
      psc_pkg::FLAGS_OFS:  rd_value[psc_pkg::FLAG_W-1:0] = flags;
      psc_pkg::MASK_OFS:   rd_value[psc_pkg::FLAG_W-1:0] = mask;
      default:             rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= psc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_ok ? rd_value : '0;
      s_axi_rresp  <= rd_ok ? psc_pkg::RESP_OKAY : psc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign irq_level = |(flags & mask);

  // Open-drain pins only ever pull low.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      blocks_enable_o         <= 1'b0;
      low_rail_indicator_o    <= 1'b0;
      low_rail_indicator_oe_o <= 1'b0;
      irq_o                   <= 1'b0;
      irq_oe_o                <= 1'b0;
    end else begin
      blocks_enable_o         <= next_state == ST_ACTIVE;
      low_rail_indicator_o    <= 1'b0;
      low_rail_indicator_oe_o <= amp_on_battery_i && (state == ST_ACTIVE);
      if (ctrl[psc_pkg::CTRL_IRQ_PP_BIT]) begin
        irq_o    <= irq_level ~^ ctrl[psc_pkg::CTRL_IRQ_HI_BIT];
        irq_oe_o <= 1'b1;
      end else begin
        irq_o    <= 1'b0;
        irq_oe_o <= irq_level ^ ctrl[psc_pkg::CTRL_IRQ_HI_BIT];
      end
    end
  end

endmodule
`default_nettype wire

// [design/psc_pkg.sv]
// Shared constants and types of the power-state controller.
package psc_pkg;

  // Clock and timing.
  localparam int CLK_PERIOD_NS     = 4;
  localparam int TRIM_LIMIT_NS     = 1500000;
  localparam int TRIM_LIMIT_CYCLES = TRIM_LIMIT_NS / CLK_PERIOD_NS;
  localparam int RAMP_TIME_NS      = 1000;
  localparam int RAMP_CYCLES       = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W           = 20;

  // Register byte offsets.
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] FLAGS_OFS  = 4'h8;
  localparam logic [3:0] MASK_OFS   = 4'hc;

  // Control fields.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_IRQ_HI_BIT = 1;
  localparam int CTRL_IRQ_PP_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Status fields.
  localparam logic [1:0] PWR_HW     = 2'h0;
  localparam logic [1:0] PWR_SW     = 2'h1;
  localparam logic [1:0] PWR_ACTIVE = 2'h2;
  localparam int STATUS_BUSY_BIT = 2;
  localparam int STATUS_BATT_BIT = 3;

  // Interrupt flag fields.
  localparam int FLAG_UP_BIT    = 0;
  localparam int FLAG_DOWN_BIT  = 1;
  localparam int FLAG_TRIM_BIT  = 2;
  localparam int FLAG_FAULT_BIT = 3;
  localparam int FLAG_W         = 4;
  localparam logic [FLAG_W-1:0] MASK_RESET = 4'h0;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Supply indications, high means good.
  typedef struct packed {
    logic core_good;
    logic core_uv_ok;
    logic speaker_uv_ok;
    logic battery_uv_ok;
    logic analog_good;
  } psc_supply_t;

endpackage

// [design/psc_sync.sv]
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module psc_sync #(
  parameter int          W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset.
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  // Data.
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit changes only once the second and third stages agree.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sync_o <= RESET_VAL;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_o[i] <= stage3[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

// [design/psc_timer.sv]
// Restartable down-counter that pulses when a loaded length has elapsed.
`timescale 1ns/1ps
`default_nettype none
module psc_timer #(
  parameter int W = 20
) (
  // Clock and reset.
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  // Control.
  input  wire logic         start_i,
  input  wire logic [W-1:0] len_i,
  output logic              done_o
);

  logic [W-1:0] count;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      count <= '0;
    end else if (start_i) begin
      count <= len_i;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  // A restart in the same cycle suppresses the pulse of the old run.
  assign done_o = (count == W'(1)) && !start_i;

endmodule
`default_nettype wire

// [sim/psc_trim_model.sv]
// Behavioural trim loader that answers each load request after a set latency.
`timescale 1ns/1ps
`default_nettype none
module psc_trim_model (
  // Clock.
  input  wire logic       clk_sys_i,
  // Request and behaviour commanded by the bench.
  input  wire logic       start_i,
  input  wire logic       fail_i,
  input  wire logic [7:0] lat_i,
  // Answer.
  output logic            done_o,
  output logic            ok_o
);
  int cnt = -1;
  initial done_o = 1'b0;
  initial ok_o = 1'b0;
  // Outside an answer the result line toggles so that a stale value is never trusted.
  always @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    ok_o <= ~ok_o;
    if (start_i) begin
      cnt <= int'(lat_i);
    end else if (cnt == 0) begin
      done_o <= 1'b1;
      ok_o <= ~fail_i;
      cnt <= -1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// [sim/psc_power_state_ctrl_properties.sv]
// Concurrent checks on the ports of the power-state controller.
`timescale 1ns/1ps
`default_nettype none
module psc_power_state_ctrl_properties #(
  parameter int TRIM_LIMIT = 20
) (
  // Clock, reset and pins.
  input wire logic                 clk_sys_i,
  input wire logic                 sys_rst_i,
  input wire logic                 hw_reset_n_i,
  input wire psc_pkg::psc_supply_t supplies_i,
  input wire logic                 amp_on_battery_i,
  // Sequencer outputs.
  input wire logic                 blocks_enable_o,
  input wire logic                 trim_load_start_o,
  input wire logic                 low_rail_indicator_o,
  input wire logic                 low_rail_indicator_oe_o,
  input wire logic                 irq_o,
  input wire logic                 irq_oe_o,
  // Bus handshakes.
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [31:0]          s_axi_rdata
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  chk_start_hw: assert property ($fell(sys_rst_i) |-> !blocks_enable_o [*8])
    else $error("active too soon after reset");
  chk_no_skip: assert property (trim_load_start_o |-> !blocks_enable_o ##1 !blocks_enable_o [*8])
    else $error("active reached without the middle state");
  chk_trim_pulse: assert property (trim_load_start_o |=> !trim_load_start_o)
    else $error("trim start longer than one cycle");
  chk_pin_forces: assert property ($fell(hw_reset_n_i) |-> ##[1:400] !blocks_enable_o)
    else $error("reset pin did not stop the active state");
  chk_core_loss: assert property ($fell(supplies_i.core_good) |-> ##[1:400] !blocks_enable_o)
    else $error("core supply loss did not stop the active state");
  chk_irq_mode: assert property (irq_o |-> irq_oe_o)
    else $error("interrupt driven high while not enabled");
  chk_lri_idle: assert property (!blocks_enable_o [*2] |-> !low_rail_indicator_oe_o && !low_rail_indicator_o)
    else $error("low rail indicator outside the active state");
  chk_lri_on: assert property ((blocks_enable_o && amp_on_battery_i) [*3] |-> low_rail_indicator_oe_o)
    else $error("low rail indicator missing on battery");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write response late");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule
bind psc_power_state_ctrl psc_power_state_ctrl_properties #(.TRIM_LIMIT(TRIM_LIMIT)) u_props (
  .clk_sys_i, .sys_rst_i, .hw_reset_n_i, .supplies_i, .amp_on_battery_i, .blocks_enable_o, .trim_load_start_o,
  .low_rail_indicator_o, .low_rail_indicator_oe_o, .irq_o, .irq_oe_o, .s_axi_awvalid, .s_axi_wvalid,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata);
`default_nettype wire

// [sim/tb_power_state_controller.sv]
// Self-checking testbench of the power-state controller.
`timescale 1ns/1ps
`default_nettype none
module tb_power_state_controller;
  logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, hw_reset_n_i = 1'b0, amp_on_battery_i = 1'b0;
  psc_pkg::psc_supply_t supplies_i = 5'h1b;
  logic blocks_enable_o, trim_load_start_o, trim_load_done_i, trim_load_ok_i;
  logic low_rail_indicator_o, low_rail_indicator_oe_o, irq_o, irq_oe_o;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic trim_fail = 1'b1;
  logic [7:0] trim_lat = 8'h05;
  logic [31:0] seed = 32'h0001135e;
  int mismatches = 0, total_checks = 0, trim_starts = 0;

  psc_power_state_ctrl #(.TRIM_LIMIT(20)) dut (.clk_sys_i, .sys_rst_i, .hw_reset_n_i, .supplies_i,
    .amp_on_battery_i, .blocks_enable_o, .trim_load_start_o, .trim_load_done_i, .trim_load_ok_i,
    .low_rail_indicator_o, .low_rail_indicator_oe_o, .irq_o, .irq_oe_o, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  psc_trim_model u_trim (.clk_sys_i, .start_i(trim_load_start_o), .fail_i(trim_fail), .lat_i(trim_lat),
    .done_o(trim_load_done_i), .ok_o(trim_load_ok_i));

  initial forever #2 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i) if (trim_load_start_o) trim_starts++;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected {oe, level} of the interrupt pin for a control word and a pending level.
  function automatic logic [1:0] irq_exp(input logic [2:0] c, input logic lvl);
    if (c[psc_pkg::CTRL_IRQ_PP_BIT]) return {1'b1, lvl == c[psc_pkg::CTRL_IRQ_HI_BIT]};
    return {lvl != c[psc_pkg::CTRL_IRQ_HI_BIT], 1'b0};
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address and data are offered together; each is released at the edge that takes it.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa;
    logic pw;
    logic ta;
    logic tw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge clk_sys_i);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge clk_sys_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    repeat (xs() & 32'h3) @(posedge clk_sys_i);
    s_axi_bready <= 1'b1;
    do @(negedge clk_sys_i); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge clk_sys_i);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk_sys_i); while (!s_axi_arready);
    @(posedge clk_sys_i);
    s_axi_arvalid <= 1'b0;
    repeat (xs() & 32'h3) @(posedge clk_sys_i);
    s_axi_rready <= 1'b1;
    do @(negedge clk_sys_i); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk_sys_i);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wrc(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask
  // Reads the status word until it shows the wanted value, under a bounded count.
  task automatic poll(input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      rd(psc_pkg::STATUS_OFS, d, r);
      n++;
    end while ((r !== psc_pkg::RESP_OKAY || d !== exp) && n < 500);
    chk(d, exp);
  endtask

  initial begin
    #(psc_pkg::CLK_PERIOD_NS * 50000);
    mismatches++;
    tally_and_finish;
  end

  initial begin
    logic [31:0] x;
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rdc(psc_pkg::CTRL_OFS, 32'h0, psc_pkg::RESP_SLVERR);
    wrc(psc_pkg::MASK_OFS, 32'hf, psc_pkg::RESP_SLVERR);
    hw_reset_n_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    rdc(psc_pkg::STATUS_OFS, 32'h0, psc_pkg::RESP_SLVERR);
    supplies_i.speaker_uv_ok <= 1'b1;
    poll(32'h1);
    rdc(psc_pkg::FLAGS_OFS, 32'h4, psc_pkg::RESP_OKAY);
    chk(trim_starts, 32'h1);
    wrc(psc_pkg::FLAGS_OFS, 32'hf, psc_pkg::RESP_OKAY);
    rdc(psc_pkg::FLAGS_OFS, 32'h0, psc_pkg::RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      x = xs();
      wrc(psc_pkg::MASK_OFS, x, psc_pkg::RESP_OKAY);
      rdc(psc_pkg::MASK_OFS, x & 32'hf, psc_pkg::RESP_OKAY);
    end
    s_axi_wstrb <= 4'he;
    wrc(psc_pkg::MASK_OFS, ~x, psc_pkg::RESP_SLVERR);
    s_axi_wstrb <= 4'hf;
    rdc(psc_pkg::MASK_OFS, x & 32'hf, psc_pkg::RESP_OKAY);
    wrc(4'h2, 32'h1, psc_pkg::RESP_SLVERR);
    wrc(psc_pkg::STATUS_OFS, 32'h2, psc_pkg::RESP_SLVERR);
    wrc(psc_pkg::MASK_OFS, 32'hf, psc_pkg::RESP_OKAY);
    wrc(psc_pkg::CTRL_OFS, 32'h7, psc_pkg::RESP_OKAY);
    poll(32'h2);
    chk({31'h0, blocks_enable_o}, 32'h1);
    rdc(psc_pkg::FLAGS_OFS, 32'h1, psc_pkg::RESP_OKAY);
    chk({30'h0, irq_oe_o, irq_o}, {30'h0, irq_exp(3'h7, 1'b1)});
    amp_on_battery_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk({30'h0, low_rail_indicator_oe_o, low_rail_indicator_o}, 32'h2);
    amp_on_battery_i <= 1'b0;
    wrc(psc_pkg::FLAGS_OFS, 32'hf, psc_pkg::RESP_OKAY);
    wrc(psc_pkg::CTRL_OFS, 32'h6, psc_pkg::RESP_OKAY);
    wrc(psc_pkg::CTRL_OFS, 32'h7, psc_pkg::RESP_OKAY);
    poll(32'h2);
    rdc(psc_pkg::FLAGS_OFS, 32'h1, psc_pkg::RESP_OKAY);
    wrc(psc_pkg::FLAGS_OFS, 32'hf, psc_pkg::RESP_OKAY);
    supplies_i.battery_uv_ok <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    supplies_i.battery_uv_ok <= 1'b1;
    poll(32'h1);
    rdc(psc_pkg::CTRL_OFS, 32'h6, psc_pkg::RESP_OKAY);
    rdc(psc_pkg::FLAGS_OFS, 32'h8, psc_pkg::RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      wrc(psc_pkg::CTRL_OFS, 32'(c) << 1, psc_pkg::RESP_OKAY);
      repeat (3) @(posedge clk_sys_i);
      chk({30'h0, irq_oe_o, irq_o}, {30'h0, irq_exp(3'(c) << 1, 1'b1)});
    end
    wrc(psc_pkg::FLAGS_OFS, 32'hf, psc_pkg::RESP_OKAY);
    repeat (3) @(posedge clk_sys_i);
    chk({30'h0, irq_oe_o, irq_o}, {30'h0, irq_exp(3'h6, 1'b0)});
    wrc(psc_pkg::CTRL_OFS, 32'h7, psc_pkg::RESP_OKAY);
    poll(32'h2);
    trim_lat <= 8'h28;
    supplies_i.core_good <= 1'b0;
    repeat (400) @(posedge clk_sys_i);
    rdc(psc_pkg::MASK_OFS, 32'h0, psc_pkg::RESP_SLVERR);
    supplies_i.core_good <= 1'b1;
    poll(32'h1);
    rdc(psc_pkg::MASK_OFS, {28'h0, psc_pkg::MASK_RESET}, psc_pkg::RESP_OKAY);
    rdc(psc_pkg::FLAGS_OFS, 32'h4, psc_pkg::RESP_OKAY);
    trim_fail <= 1'b0;
    trim_lat <= 8'h05;
    hw_reset_n_i <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    rdc(psc_pkg::CTRL_OFS, 32'h0, psc_pkg::RESP_SLVERR);
    hw_reset_n_i <= 1'b1;
    poll(32'h1);
    rdc(psc_pkg::CTRL_OFS, {29'h0, psc_pkg::CTRL_RESET}, psc_pkg::RESP_OKAY);
    rdc(psc_pkg::FLAGS_OFS, 32'h0, psc_pkg::RESP_OKAY);
    chk(trim_starts, 32'h3);
    tally_and_finish;
  end
endmodule
`default_nettype wire
